//--- rtl/calc_fe_pkg.sv
// Shared constants, types and decode functions of the calculator front end
package calc_fe_pkg;
  // Timing, all derived from the 250 MHz core clock
  localparam int    CLK_PERIOD_PS = 4000;
  localparam int    DIGIT_TIME_NS = 83000;
  localparam int    DIGIT_CYC     = DIGIT_TIME_NS * 1000 / CLK_PERIOD_PS;
  localparam int    BLANK_TIME_NS = 4500;
  localparam int    BLANK_CYC     = (BLANK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int    CUTOFF_TIME_S = 35;
  localparam longint CUTOFF_CYC   = longint'(CUTOFF_TIME_S) * 64'h0000_00e8_d4a5_1000
                                    / longint'(CLK_PERIOD_PS);
  localparam int    ENTRY_WORDS   = 9;
  localparam int    RELEASE_WORDS = 16;

  // Geometry
  localparam int NUM_POS = 9;
  localparam int NUM_RET = 4;
  localparam int NUM_DIG = 8;

  // Number format and display codes
  localparam logic [3:0] NO_POINT  = 4'h f;
  localparam logic [3:0] MAX_CNT   = 4'h 8;
  localparam logic [3:0] ROUND_UP  = 4'h 5;
  localparam logic [6:0] SEG_BLANK = 7'h 00;
  localparam logic [6:0] SEG_MINUS = 7'h 40;

  typedef struct packed {
    logic                neg;
    logic [3:0]          cnt;   // Digits entered, left justified
    logic [3:0]          pt;    // Digits before the point, NO_POINT if none
    logic [7:0][3:0]     dig;   // dig[0] is the leftmost digit
  } num_t;

  typedef struct packed {
    logic [8:0] digit_en;       // One-hot, bit 0 is the leftmost position
    logic [6:0] segment_drive;  // Bit 0 segment_drive_first, bit 6 segment_drive_last
    logic       dp;
  } disp_t;

  typedef enum logic [4:0] {
    FN_DIGIT = 5'h 00, FN_POINT = 5'h 01, FN_CHS  = 5'h 02, FN_CLR    = 5'h 03,
    FN_ADD   = 5'h 04, FN_SUB   = 5'h 05, FN_MUL  = 5'h 06, FN_DIV    = 5'h 07,
    FN_EQ    = 5'h 08, FN_PCT   = 5'h 09, FN_MSTO = 5'h 0a, FN_MREC   = 5'h 0b,
    FN_MCLR  = 5'h 0c, FN_RATE  = 5'h 0d, FN_PER  = 5'h 0e, FN_XCHG   = 5'h 0f,
    FN_OTHER = 5'h 10, FN_NONE  = 5'h 11
  } fn_t;

  typedef enum logic [1:0] {
    Q_IDLE = 2'b00, Q_ENTRY = 2'b01, Q_HELD = 2'b10, Q_RELEASE = 2'b11
  } qual_state_t;

  // Key code is scan position times four plus return line
  function automatic fn_t key_fn(input logic [5:0] code);
    if (code < 6'h 0a) begin
      return FN_DIGIT;
    end
    unique case (code)
      6'h 0a: return FN_POINT;
      6'h 0b: return FN_CHS;
      6'h 0c: return FN_CLR;
      6'h 0d: return FN_ADD;
      6'h 0e: return FN_SUB;
      6'h 0f: return FN_MUL;
      6'h 10: return FN_DIV;
      6'h 11: return FN_EQ;
      6'h 12: return FN_PCT;
      6'h 13: return FN_MSTO;
      6'h 14: return FN_MREC;
      6'h 15: return FN_MCLR;
      6'h 16: return FN_RATE;
      6'h 17: return FN_PER;
      6'h 18: return FN_XCHG;
      default: return (code < 6'h 20) ? FN_OTHER : FN_NONE;
    endcase
  endfunction

  function automatic logic [6:0] seg7(input logic [3:0] d);
    unique case (d)
      4'h 0: return 7'h 3f;
      4'h 1: return 7'h 06;
      4'h 2: return 7'h 5b;
      4'h 3: return 7'h 4f;
      4'h 4: return 7'h 66;
      4'h 5: return 7'h 6d;
      4'h 6: return 7'h 7d;
      4'h 7: return 7'h 07;
      4'h 8: return 7'h 7f;
      4'h 9: return 7'h 6f;
      default: return SEG_BLANK;
    endcase
  endfunction
endpackage

//--- rtl/key_qualifier.sv
// Key entry and release time-out qualifier, paced in word times
`timescale 1ns/10ps
`default_nettype none
module key_qualifier
  import calc_fe_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Word pacing and key level seen over the last word
  input  wire logic word_tick,
  input  wire logic key_level,
  // Results
  output var  logic accept,
  output var  logic released
);
  qual_state_t state_r;
  logic [4:0]  cnt_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r  <= Q_IDLE;
      cnt_r    <= 5'h 00;
      accept   <= 1'b0;
      released <= 1'b0;
    end else begin
      accept   <= 1'b0;
      released <= 1'b0;
      if (word_tick) begin
        unique case (state_r)
          Q_IDLE: begin
            if (key_level) begin
              state_r <= Q_ENTRY;
              cnt_r   <= 5'h 01;
            end
          end
          Q_ENTRY: begin
            // Level checked every other word; a bad level restarts in idle
            if (cnt_r[0] && !key_level) begin  // see [RULE_15]
              state_r <= Q_IDLE;
              cnt_r   <= 5'h 00;
            end else if (cnt_r == 5'(ENTRY_WORDS - 1)) begin
              state_r <= key_level ? Q_HELD : Q_IDLE;  // see [RULE_15]
              accept  <= key_level;
              cnt_r   <= 5'h 00;
            end else begin
              cnt_r <= cnt_r + 5'h 01;
            end
          end
          Q_HELD: begin
            if (!key_level) begin
              state_r <= Q_RELEASE;
              cnt_r   <= 5'h 01;
            end
          end
          Q_RELEASE: begin
            if (cnt_r[0] && key_level) begin  // see [RULE_15]
              state_r <= Q_HELD;
              cnt_r   <= 5'h 00;
            end else if (cnt_r == 5'(RELEASE_WORDS - 1)) begin
              state_r  <= Q_IDLE;
              released <= 1'b1;  // see [RULE_15]
              cnt_r    <= 5'h 00;
            end else begin
              cnt_r <= cnt_r + 5'h 01;
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/calc_front_end.sv
// Calculator key scan, key qualification, working registers and display drive
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// [RULE_01] Reset clears every register including memory
// [RULE_02] Leftmost digit shows minus or leading point
// [RULE_03] Left justified, trailing fraction zeros unlit
// [RULE_04] Idle cutoff blanks numerals, lights all points
// [RULE_05] Thirty-two keys on four returns, nine scans
// [RULE_06] Six working registers held
// [RULE_07] Memory changes only through memory keys
// [RULE_08] Floating entry; terminators round to two places
// [RULE_09] Ready output reports idle or busy
// [RULE_10] Word time is nine digit times
// [RULE_11] Each digit enabled one digit time
// [RULE_12] Segments blanked between digit times
// [RULE_13] Entry and release time-outs bounded
// [RULE_14] Rate and period registers for finance
// [RULE_15] Nine words entry, sixteen release, restart
// [RULE_16] Ready low from accept until release
// [RULE_17] Overflow or divide by zero shows error
// [RULE_18] Fixed scan order, returns sampled each digit
// [RULE_19] Key press ends cutoff, restarts timer
module calc_front_end
  import calc_fe_pkg::*;
#(
  parameter int     DIGIT_CYC_P  = DIGIT_CYC,
  parameter int     BLANK_CYC_P  = BLANK_CYC,
  parameter longint CUTOFF_CYC_P = CUTOFF_CYC
) (
  // Clock and power-on clear
  input  wire logic             mclk,
  input  wire logic             resetn,
  // Key matrix returns, bit 0 key_return_line_first, bit 3 key_return_line_last
  input  wire logic [3:0]       key_return,
  // Display drive
  output var  disp_t            disp,
  // Status
  output var  logic             ready
);
  localparam int CYC_W = $clog2(DIGIT_CYC_P + 1);

  logic [3:0]       ks1_r, ks2_r, ks3_r, keys_r;
  logic [CYC_W-1:0] cyc_r;
  logic [3:0]       pos_r;
  logic             digit_end, word_tick;
  logic             hit_r, word_hit_r;
  logic [5:0]       code_r, word_code_r, key_code_r;
  logic             accept, released, exec_r, poc_r;
  num_t             x_r, y_r, a_r, i_r, n_r, m_r;
  logic             entering_r, err_r, cutoff_r;
  logic [63:0]      idle_cnt_r;
  fn_t              fn;
  num_t             x_round;
  logic             round_ovf, div_zero, lit_sel;
  logic [3:0]       lit_cnt, k;

  // Returns pass three flops; a change counts once the last two agree
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ks1_r  <= 4'h 0;
      ks2_r  <= 4'h 0;
      ks3_r  <= 4'h 0;
      keys_r <= 4'h 0;
    end else begin
      ks1_r <= key_return;
      ks2_r <= ks1_r;
      ks3_r <= ks2_r;
      if (ks2_r == ks3_r) begin
        keys_r <= ks3_r;
      end
    end
  end

  // Digit and word timing
  assign digit_end = (cyc_r == CYC_W'(DIGIT_CYC_P - 1));
  assign word_tick = digit_end && (pos_r == 4'(NUM_POS - 1));  // see [RULE_10]

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cyc_r <= '0;
      pos_r <= 4'h 0;
    end else if (digit_end) begin  // see [RULE_11]
      cyc_r <= '0;
      pos_r <= word_tick ? 4'h 0 : pos_r + 4'h 1;  // see [RULE_18]
    end else begin
      cyc_r <= cyc_r + CYC_W'(1);
    end
  end

  // Locate a closed key during the word; lowest position and line wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hit_r       <= 1'b0;
      code_r      <= 6'h 00;
      word_hit_r  <= 1'b0;
      word_code_r <= 6'h 00;
    end else if (digit_end) begin  // see [RULE_18]
      if (word_tick) begin
        word_hit_r  <= hit_r || (keys_r != 4'h 0);
        word_code_r <= hit_r ? code_r : {pos_r[3:0], 2'b00} + 6'(first_line(keys_r));
        hit_r       <= 1'b0;
      end else if (!hit_r && keys_r != 4'h 0) begin
        hit_r  <= 1'b1;
        code_r <= {pos_r[3:0], 2'b00} + 6'(first_line(keys_r));  // see [RULE_05]
      end
    end
  end

  function automatic logic [1:0] first_line(input logic [3:0] r);
    logic [1:0] l;
    l = 2'd3;
    for (int j = NUM_RET - 1; j >= 0; j--) begin
      if (r[j]) begin
        l = 2'(j);
      end
    end
    return l;
  endfunction

  key_qualifier u_qual (  // see [RULE_13]
    .mclk      (mclk),
    .resetn    (resetn),
    .word_tick (word_tick),
    .key_level (word_hit_r),
    .accept    (accept),
    .released  (released)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      key_code_r <= 6'h 00;
      exec_r     <= 1'b0;
    end else begin
      exec_r <= accept && !err_r && !poc_r;
      if (accept) begin
        key_code_r <= word_code_r;
      end
    end
  end

  assign fn       = exec_r ? key_fn(key_code_r) : FN_NONE;
  assign div_zero = (fn == FN_DIV) && (lit_count(x_r) == 4'h 0);

  // Round to two places after the point, carry may overflow
  always_comb begin
    logic [3:0] keep;
    logic       up;
    keep      = x_r.pt + 4'h 2;
    up        = 1'b0;
    x_round   = x_r;
    if (x_r.pt != NO_POINT && x_r.cnt > keep) begin  // see [RULE_08]
      up          = (x_r.dig[keep[2:0]] >= ROUND_UP);
      x_round.cnt = keep;
      for (int j = NUM_DIG - 1; j >= 0; j--) begin
        if (4'(j) < keep && up) begin
          if (x_r.dig[j] == 4'h 9) begin
            x_round.dig[j] = 4'h 0;
          end else begin
            x_round.dig[j] = x_r.dig[j] + 4'h 1;
            up = 1'b0;
          end
        end
      end
    end
    round_ovf = up;
  end

  // Digits lit after dropping trailing zeros behind the point
  function automatic logic [3:0] lit_count(input num_t v);
    logic [3:0] c;
    c = v.cnt;
    for (int j = NUM_DIG - 1; j >= 0; j--) begin
      if (v.pt != NO_POINT && 4'(j) + 4'h 1 == c && 4'(j) >= v.pt && v.dig[j] == 4'h 0) begin
        c = c - 4'h 1;  // see [RULE_03]
      end
    end
    return c;
  endfunction

  // Working registers; memory lives in its own process
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin  // see [RULE_01]
      x_r        <= '0;
      y_r        <= '0;
      a_r        <= '0;
      i_r        <= '0;
      n_r        <= '0;
      entering_r <= 1'b0;
    end else if (fn != FN_NONE) begin  // see [RULE_06]
      entering_r <= (fn == FN_DIGIT) || (fn == FN_POINT);
      unique case (fn)
        FN_DIGIT: begin
          if (!entering_r) begin
            x_r        <= '0;
            x_r.pt     <= NO_POINT;
            x_r.cnt    <= 4'h 1;
            x_r.dig[0] <= key_code_r[3:0];
          end else if (x_r.cnt < MAX_CNT) begin
            x_r.dig[x_r.cnt[2:0]] <= key_code_r[3:0];
            x_r.cnt <= x_r.cnt + 4'h 1;
          end
        end
        FN_POINT: begin
          if (!entering_r) begin
            x_r <= '0;
          end else begin
            x_r.pt <= x_r.cnt;
          end
        end
        FN_CHS:  x_r.neg <= ~x_r.neg;
        FN_CLR: begin
          x_r <= '0;
          if (!entering_r) begin
            y_r <= '0;
            a_r <= '0;
          end
        end
        FN_ADD, FN_SUB: a_r <= x_r;
        FN_MUL:  y_r <= x_r;
        FN_DIV:  y_r <= div_zero ? y_r : x_r;
        FN_EQ, FN_PCT: x_r <= round_ovf ? '0 : x_round;  // see [RULE_08]
        FN_MREC: x_r <= m_r;
        FN_RATE: i_r <= x_r;  // see [RULE_14]
        FN_PER:  n_r <= x_r;  // see [RULE_14]
        FN_XCHG: begin
          x_r <= y_r;
          y_r <= x_r;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      m_r <= '0;  // see [RULE_01]
    end else if (fn == FN_MSTO) begin  // see [RULE_07]
      m_r <= x_r;
    end else if (fn == FN_MCLR) begin
      m_r <= '0;
    end
  end

  // Error indication, cleared by the next accepted key
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      err_r <= 1'b0;
    end else if (div_zero || ((fn == FN_EQ || fn == FN_PCT) && round_ovf)) begin
      err_r <= 1'b1;  // see [RULE_17]
    end else if (accept) begin
      err_r <= 1'b0;  // see [RULE_17]
    end
  end

  // Ready and power-on clear; no key is taken until clearing is done
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      poc_r <= 1'b1;
      ready <= 1'b0;
    end else begin
      poc_r <= 1'b0;  // see [RULE_01]
      if (poc_r || released) begin
        ready <= 1'b1;  // see [RULE_16]
      end else if (accept) begin
        ready <= 1'b0;  // see [RULE_09]
      end
    end
  end

  // Inactivity cutoff
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt_r <= 64'h 0000_0000_0000_0000;
      cutoff_r   <= 1'b0;
    end else if (accept) begin
      idle_cnt_r <= 64'h 0000_0000_0000_0000;  // see [RULE_19]
      cutoff_r   <= 1'b0;  // see [RULE_19]
    end else if (idle_cnt_r == 64'(CUTOFF_CYC_P - 1)) begin
      cutoff_r <= 1'b1;  // see [RULE_04]
    end else begin
      idle_cnt_r <= idle_cnt_r + 64'h 0000_0000_0000_0001;
    end
  end

  // Display drive for the position being scanned
  assign k       = pos_r - 4'h 1;
  assign lit_cnt = lit_count(x_r);
  assign lit_sel = (k < lit_cnt) || (lit_cnt == 4'h 0 && k == 4'h 0);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      disp <= '0;
    end else begin
      disp.digit_en <= 9'(1) << pos_r;  // see [RULE_11]
      if (cyc_r < CYC_W'(BLANK_CYC_P)) begin
        disp.segment_drive <= SEG_BLANK;  // see [RULE_12]
        disp.dp            <= 1'b0;
      end else if (cutoff_r) begin
        disp.segment_drive <= SEG_BLANK;  // see [RULE_04]
        disp.dp            <= 1'b1;
      end else if (err_r) begin
        disp.segment_drive <= seg7(4'h 0);  // see [RULE_17]
        disp.dp            <= 1'b1;
      end else if (pos_r == 4'h 0) begin
        disp.segment_drive <= x_r.neg ? SEG_MINUS : SEG_BLANK;  // see [RULE_02]
        disp.dp            <= (x_r.pt == 4'h 0);  // see [RULE_02]
      end else begin
        disp.segment_drive <= lit_sel ? seg7(x_r.dig[k[2:0]]) : SEG_BLANK;  // see [RULE_03]
        disp.dp            <= (x_r.pt != NO_POINT) && (x_r.pt == pos_r);
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/calc_front_end_chk.sv
// Checker for scan timing, ready handshake and cutoff of the front end
`timescale 1ns/10ps
`default_nettype none
module calc_front_end_chk
  import calc_fe_pkg::*;
#(
  parameter int     DIGIT_CYC_P  = DIGIT_CYC,
  parameter int     BLANK_CYC_P  = BLANK_CYC,
  parameter longint CUTOFF_CYC_P = CUTOFF_CYC
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Observed ports
  input  wire logic [3:0] key_return,
  input  wire disp_t      disp,
  input  wire logic       ready
);
  localparam longint WORD = 9 * DIGIT_CYC_P;
  logic [8:0]  prev_en_r;
  logic [39:0] dig_cnt_r;
  logic        live_r;
  logic [39:0] low_cnt_r;
  logic [39:0] run_cnt_r;
  logic        moved;
  assign moved = (disp.digit_en != prev_en_r);

  // Cycles since the digit enable last changed
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prev_en_r <= '0;
      dig_cnt_r <= '0;
      live_r    <= 1'b0;
    end else begin
      prev_en_r <= disp.digit_en;
      dig_cnt_r <= moved ? '0 : dig_cnt_r + 40'h1;
      live_r    <= live_r | moved;
    end
  end

  // Quiet time on the returns and length of the current press
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      low_cnt_r <= '0;
      run_cnt_r <= '0;
    end else begin
      low_cnt_r <= (key_return != 4'h0) ? '0 : low_cnt_r + 40'h1;
      run_cnt_r <= (low_cnt_r > WORD) ? '0 : run_cnt_r + 40'h1;
    end
  end

  onehot_scan_a: assert property (@(posedge mclk) disable iff (!resetn)
    live_r |-> $onehot(disp.digit_en)) else $error("scan enable not one-hot");
  scan_order_a: assert property (@(posedge mclk) disable iff (!resetn)
    live_r && moved |-> disp.digit_en == {prev_en_r[7:0], prev_en_r[8]})
    else $error("scan order broken");
  digit_time_a: assert property (@(posedge mclk) disable iff (!resetn)
    live_r && moved |-> dig_cnt_r == 40'(DIGIT_CYC_P - 1)) else $error("digit time wrong");
  seg_blank_a: assert property (@(posedge mclk) disable iff (!resetn)
    live_r && (moved || dig_cnt_r < 40'(BLANK_CYC_P - 1))
    |-> disp.segment_drive == SEG_BLANK && !disp.dp)
    else $error("segments lit in blanking");
  ready_fall_a: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(ready) |-> run_cnt_r >= 40'(8 * WORD)) else $error("key taken too early");
  ready_rise_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(ready) && $past(resetn, 2) |-> low_cnt_r >= 40'(14 * WORD))
    else $error("release taken too early");
  ready_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    !ready && key_return != 4'h0 |=> !ready) else $error("ready high with key held");
  cutoff_show_a: assert property (@(posedge mclk) disable iff (!resetn)
    live_r && !moved && low_cnt_r > 40'(CUTOFF_CYC_P + 2 * WORD)
    && dig_cnt_r >= 40'(BLANK_CYC_P)
    |-> disp.segment_drive == SEG_BLANK && disp.dp) else $error("display not cut off");
endmodule
bind calc_front_end calc_front_end_chk #(
  .DIGIT_CYC_P (DIGIT_CYC_P),
  .BLANK_CYC_P (BLANK_CYC_P),
  .CUTOFF_CYC_P(CUTOFF_CYC_P)
) chk (
  .mclk      (mclk),
  .resetn    (resetn),
  .key_return(key_return),
  .disp      (disp),
  .ready     (ready)
);
`default_nettype wire

//--- verification/key_matrix_model.sv
// Key matrix model: one closed key joins a scan position to a return line
`timescale 1ns/10ps
`default_nettype none
module key_matrix_model (
  // Scan positions from the display drive
  input  wire logic [8:0] digit_en,
  // Key held by the bench
  input  wire logic       press_on,
  input  wire logic [3:0] press_pos,
  input  wire logic [1:0] press_line,
  // Return lines, pulled low while open
  output var  logic [3:0] key_return
);
  always_comb begin
    key_return             = 4'h0;
    key_return[press_line] = press_on && digit_en[press_pos];
  end
endmodule
`default_nettype wire

//--- verification/test_calc_front_end.sv
// Self-checking bench for the calculator key and display front end
`timescale 1ns/10ps
`default_nettype none
module test_calc_front_end;
  import calc_fe_pkg::*;
  localparam int     DC   = 32;
  localparam int     BLK  = 3;
  localparam longint CUT  = 16000;
  localparam int     WORD = 9 * DC;
  localparam int     CEIL = 90000;
  logic       mclk;
  logic       resetn;
  logic [3:0] key_return;
  disp_t      disp;
  logic       ready;
  logic       press_on;
  logic [3:0] press_pos;
  logic [1:0] press_line;
  int         errors;
  int         samples_checked;
  int         cycles = 0;

  calc_front_end #(.DIGIT_CYC_P(DC), .BLANK_CYC_P(BLK), .CUTOFF_CYC_P(CUT)) dut (
    .mclk      (mclk),
    .resetn    (resetn),
    .key_return(key_return),
    .disp      (disp),
    .ready     (ready)
  );
  key_matrix_model km (
    .digit_en  (disp.digit_en),
    .press_on  (press_on),
    .press_pos (press_pos),
    .press_line(press_line),
    .key_return(key_return)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      errors = errors + 1;
      tally_and_finish();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Wait for the start of a position, then past its blanking
  task automatic look(input int p);
    int n;
    n = 0;
    while (disp.digit_en === 9'(1 << p) && n < WORD) begin
      tick(1);
      n++;
    end
    while (disp.digit_en !== 9'(1 << p) && n < 3 * WORD) begin
      tick(1);
      n++;
    end
    tick(BLK + 20);
  endtask

  task automatic set_key(input int pos, input int line, input logic on);
    press_pos  = 4'(pos);
    press_line = 2'(line);
    press_on   = on;
  endtask

  // Whole key stroke: held until taken, released until idle again
  task automatic key(input int pos, input int line);
    int n;
    set_key(pos, line, 1'b1);
    tick(8 * WORD);
    check({7'h00, ready}, 8'h01);
    tick(5 * WORD);
    check({7'h00, ready}, 8'h00);
    set_key(pos, line, 1'b0);
    tick(14 * WORD);
    check({7'h00, ready}, 8'h00);
    n = 0;
    while (ready !== 1'b1 && n < 6 * WORD) begin
      tick(1);
      n++;
    end
    check({7'h00, ready}, 8'h01);
  endtask

  task automatic t_reset();
    check(disp[16:9], 8'h00);
    check({6'h00, disp[8], ready}, 8'h00);
    resetn = 1'b1;
    tick(2);
    check({7'h00, ready}, 8'h01);
  endtask

  // A cleared value has its point before the first digit
  task automatic t_idle();
    look(0);
    check({disp.dp, disp.segment_drive}, 8'h80);
    look(1);
    check({disp.dp, disp.segment_drive}, 8'h3f);
    look(2);
    check({disp.dp, disp.segment_drive}, 8'h00);
    set_key(1, 1, 1'b1);
    tick(4 * WORD);
    set_key(1, 1, 1'b0);
    tick(20 * WORD);
    check({7'h00, ready}, 8'h01);
    look(1);
    check({disp.dp, disp.segment_drive}, 8'h3f);
  endtask

  task automatic t_entry();
    key(1, 1);
    look(1);
    check({disp.dp, disp.segment_drive}, 8'h6d);
    look(2);
    check({disp.dp, disp.segment_drive}, 8'h00);
    key(2, 3);
    look(0);
    check({disp.dp, disp.segment_drive}, {1'b0, SEG_MINUS});
  endtask

  task automatic t_error();
    key(3, 0);
    look(0);
    check({disp.dp, disp.segment_drive}, 8'h80);
    look(1);
    check({disp.dp, disp.segment_drive}, 8'h3f);
    key(4, 0);
    look(1);
    check({disp.dp, disp.segment_drive}, 8'hbf);
    look(8);
    check({disp.dp, disp.segment_drive}, 8'hbf);
  endtask

  task automatic t_cutoff();
    tick(int'(CUT) + 3 * WORD);
    look(1);
    check({disp.dp, disp.segment_drive}, 8'h80);
    look(5);
    check({disp.dp, disp.segment_drive}, 8'h80);
    key(1, 1);
    look(5);
    check({disp.dp, disp.segment_drive}, 8'h00);
  endtask

  initial begin
    resetn          = 1'b0;
    errors          = 0;
    samples_checked = 0;
    set_key(0, 0, 1'b0);
    tick(8);
    t_reset();
    t_idle();
    t_entry();
    t_error();
    t_cutoff();
    tally_and_finish();
  end
endmodule
`default_nettype wire
